// ### logic/xdm_defines.svh
// Offsets, field positions, reset values and cycle counts of the executor
`ifndef XDM_DEFINES_SVH
`define XDM_DEFINES_SVH

// Register byte offsets on the APB window
`define XDM_OFF_CTRL      8'h00
`define XDM_OFF_WREG      8'h04
`define XDM_OFF_FLAGS     8'h08
`define XDM_OFF_MADDR     8'h0C
`define XDM_OFF_MDATA     8'h10
`define XDM_OFF_STAT      8'h14

// Control word fields
`define XDM_CTRL_OP_LSB   0
`define XDM_CTRL_BIT_LSB  8
`define XDM_CTRL_ADR_LSB  16
`define XDM_CTRL_GO       31

// Status word fields
`define XDM_STAT_BUSY     0
`define XDM_STAT_SKIP     1
`define XDM_STAT_CYC_LSB  4

// Data memory geometry: every section reached by a flat address
`define XDM_AW            9
`define XDM_MEM_DEPTH     512

// Reset values
`define XDM_WREG_RST      8'h00
`define XDM_FLAGS_RST     6'h00
`define XDM_CYC_RST       2'h0

// Instruction lengths in clock cycles
`define XDM_CYC_PLAIN     2'h2
`define XDM_CYC_SKIP      2'h3

`endif

// ### logic/xdm_pkg.sv
// Types shared by the extended data memory executor
package xdm_pkg;

  // Instruction selector
  typedef enum logic [4:0] {
    op_far_move_to_memory, op_far_or_to_register, op_far_or_to_memory,
    op_far_rotate_left, op_far_rotate_left_to_reg,
    op_far_rotate_left_thru_carry, op_far_rotl_thru_carry_to_reg,
    op_far_rotate_right, op_far_rotate_right_to_reg,
    op_far_rotate_right_thru_carry, op_far_rotr_thru_carry_to_reg,
    op_far_subtract_borrow_to_reg, op_far_subtract_borrow_to_mem,
    op_far_subtract_to_reg, op_far_subtract_to_mem,
    op_far_decrement_skip, op_far_decrement_skip_to_reg,
    op_far_increment_skip, op_far_increment_skip_to_reg,
    op_far_set_ones, op_far_set_ones_bit, op_far_nonzero_test_skip_bit,
    op_far_nonzero_test_skip, op_far_nibble_exchange
  } xdm_op_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    st_idle  = 4'h1,
    st_read  = 4'h2,
    st_write = 4'h4,
    st_dummy = 4'h8
  } xdm_state_t;

  // Status flags, carry in bit 0
  typedef struct packed {
    logic cz;
    logic sc;
    logic ov;
    logic ac;
    logic z;
    logic c;
  } xdm_flags_t;

  // Latched instruction
  typedef struct packed {
    xdm_op_t    op;
    logic [2:0] bit_sel;
    logic [8:0] addr;
  } xdm_instr_t;

endpackage : xdm_pkg

// ### logic/xdm_alu.sv
// Combinational result, flag and skip logic of the executor
`timescale 1ns/10ps
module xdm_alu (
  input  xdm_pkg::xdm_op_t    i_op,
  input  wire logic [2:0]     i_bit_sel,
  input  wire logic [7:0]     i_wreg,
  input  wire logic [7:0]     i_mem,
  input  xdm_pkg::xdm_flags_t i_flags,
  output logic [7:0]          o_res,
  output xdm_pkg::xdm_flags_t o_flags,
  output logic                o_to_mem,
  output logic                o_to_reg,
  output logic                o_skip
);
  import xdm_pkg::*;

  // Nonzero test, used by many branches
  function automatic logic nz(input logic [7:0] v);
    nz = |v;
  endfunction : nz

  logic       is_sbc;  // Borrow-in variants
  logic       is_sub;  // Any subtraction
  logic       bin;     // Borrow input
  logic [8:0] diff;    // Full difference with borrow out
  logic [4:0] half;    // Low nibble difference
  logic       ov;      // Signed overflow
  logic [7:0] mask;    // Selected bit
  logic [7:0] dec;     // Byte minus one
  logic [7:0] inc;     // Byte plus one
  logic [7:0] orv;     // Bitwise OR

  assign is_sbc = (i_op == op_far_subtract_borrow_to_reg) ||
                  (i_op == op_far_subtract_borrow_to_mem);
  assign is_sub = is_sbc || (i_op == op_far_subtract_to_reg) ||
                  (i_op == op_far_subtract_to_mem);
  assign bin    = is_sbc & ~i_flags.c;
  assign diff   = {1'b0, i_wreg} - {1'b0, i_mem} - {8'h00, bin};
  assign half   = {1'b0, i_wreg[3:0]} - {1'b0, i_mem[3:0]} - {4'h0, bin};
  assign ov     = (i_wreg[7] ^ i_mem[7]) & (diff[7] ^ i_wreg[7]);
  assign mask   = 8'h01 << i_bit_sel;
  assign dec    = i_mem - 8'h01;
  assign inc    = i_mem + 8'h01;
  assign orv    = i_wreg | i_mem;

  // Per-instruction result and destination
  always_comb begin
    o_res    = i_mem;
    o_flags  = i_flags;
    o_to_mem = 1'b0;
    o_to_reg = 1'b0;
    o_skip   = 1'b0;
    case (i_op)
      op_far_move_to_memory: begin
        o_res    = i_wreg;
        o_to_mem = 1'b1;
      end
      op_far_or_to_register, op_far_or_to_memory: begin
        o_res     = orv;
        o_to_mem  = (i_op == op_far_or_to_memory);
        o_to_reg  = !o_to_mem;
        o_flags.z = ~nz(orv);
      end
      op_far_rotate_left, op_far_rotate_left_to_reg: begin
        o_res    = {i_mem[6:0], i_mem[7]};
        o_to_mem = (i_op == op_far_rotate_left);
        o_to_reg = !o_to_mem;
      end
      op_far_rotate_left_thru_carry, op_far_rotl_thru_carry_to_reg: begin
        o_res     = {i_mem[6:0], i_flags.c};
        o_flags.c = i_mem[7];
        o_to_mem  = (i_op == op_far_rotate_left_thru_carry);
        o_to_reg  = !o_to_mem;
      end
      op_far_rotate_right, op_far_rotate_right_to_reg: begin
        o_res    = {i_mem[0], i_mem[7:1]};
        o_to_mem = (i_op == op_far_rotate_right);
        o_to_reg = !o_to_mem;
      end
      op_far_rotate_right_thru_carry, op_far_rotr_thru_carry_to_reg: begin
        o_res     = {i_flags.c, i_mem[7:1]};
        o_flags.c = i_mem[0];
        o_to_mem  = (i_op == op_far_rotate_right_thru_carry);
        o_to_reg  = !o_to_mem;
      end
      op_far_subtract_borrow_to_reg, op_far_subtract_to_reg: begin
        o_res    = diff[7:0];
        o_to_reg = 1'b1;
      end
      op_far_subtract_borrow_to_mem, op_far_subtract_to_mem: begin
        o_res    = diff[7:0];
        o_to_mem = 1'b1;
      end
      op_far_decrement_skip, op_far_decrement_skip_to_reg: begin
        o_res    = dec;
        o_to_mem = (i_op == op_far_decrement_skip);
        o_to_reg = !o_to_mem;
        o_skip   = ~nz(dec);
      end
      op_far_increment_skip, op_far_increment_skip_to_reg: begin
        o_res    = inc;
        o_to_mem = (i_op == op_far_increment_skip);
        o_to_reg = !o_to_mem;
        o_skip   = ~nz(inc);
      end
      op_far_set_ones: begin
        o_res    = 8'hFF;
        o_to_mem = 1'b1;
      end
      op_far_set_ones_bit: begin
        o_res    = i_mem | mask;
        o_to_mem = 1'b1;
      end
      op_far_nonzero_test_skip_bit: begin
        o_skip = nz(i_mem & mask);
      end
      op_far_nonzero_test_skip: begin
        o_to_mem = 1'b1;
        o_skip   = nz(i_mem);
      end
      op_far_nibble_exchange: begin
        o_res    = {i_mem[3:0], i_mem[7:4]};
        o_to_mem = 1'b1;
      end
      default: begin
      end
    endcase
    // Six subtraction flags
    if (is_sub) begin
      o_flags.c  = ~diff[8];
      o_flags.ac = ~half[4];
      o_flags.z  = ~nz(diff[7:0]);
      o_flags.ov = ov;
      o_flags.sc = ov ^ diff[7];
      o_flags.cz = is_sbc ? (~nz(diff[7:0]) & i_flags.cz) : ~nz(diff[7:0]);
    end
  end

endmodule : xdm_alu

// ### logic/xdm_exec.sv
// Extended data memory executor: APB registers, data memory and sequencer
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "xdm_defines.svh"

module xdm_exec (
  input  wire logic           i_clk,
  input  wire logic           i_rst_b,
  input  wire logic           i_psel,
  input  wire logic           i_penable,
  input  wire logic           i_pwrite,
  input  wire logic [7:0]     i_paddr,
  input  wire logic [31:0]    i_pwdata,
  output logic [31:0]         o_prdata,
  output logic                o_pready,
  output logic                o_pslverr,
  output logic [7:0]          o_working_register,
  output xdm_pkg::xdm_flags_t o_flags,
  output logic                o_busy,
  output logic                o_skip_dummy
);
  import xdm_pkg::*;

  // Register map decode
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `XDM_OFF_CTRL)  || (a == `XDM_OFF_WREG) ||
             (a == `XDM_OFF_FLAGS) || (a == `XDM_OFF_MADDR) ||
             (a == `XDM_OFF_MDATA) || (a == `XDM_OFF_STAT);
  endfunction : mapped

  // Storage
  logic [7:0]           mem_r [`XDM_MEM_DEPTH]; // Flat data memory
  xdm_state_t           st_r;                   // Sequencer state
  xdm_instr_t           instr_r;                // Latched instruction
  logic [7:0]           wreg_r;                 // Working register
  xdm_flags_t           flags_r;                // Status flags
  logic [`XDM_AW-1:0]   maddr_r;                // Memory window pointer
  logic [7:0]           mem_q_r;                // Operand fetched in read
  logic                 skip_r;                 // Last instruction skipped
  logic [1:0]           cyc_r;                  // Cycles used by last one
  logic [31:0]          rdata_r;                // Read data

  // Bus and ALU wiring
  logic                 setup;      // APB setup phase
  logic                 acc;        // APB access phase
  logic                 wr;         // Accepted write cycle
  logic                 bad;        // Error answer
  logic                 busy;       // Instruction in flight
  logic                 go;         // Launch instruction
  logic [7:0]           alu_res;    // ALU result
  xdm_flags_t           alu_flags;  // ALU flags
  logic                 alu_to_mem; // Write memory
  logic                 alu_to_reg; // Write working register
  logic                 alu_skip;   // Skip condition
  logic                 do_write;   // Result commit cycle

  assign busy     = (st_r != st_idle);
  assign setup    = i_psel & ~i_penable;
  assign acc      = i_psel & i_penable;
  assign do_write = (st_r == st_write);

  // Unmapped address, or write while running to any register but MADDR, is refused
  assign bad = ~mapped(i_paddr) |
               (i_pwrite & busy & (i_paddr != `XDM_OFF_MADDR));
  assign wr  = acc & i_pwrite & ~bad;
  assign go  = wr & (i_paddr == `XDM_OFF_CTRL) & i_pwdata[`XDM_CTRL_GO];

  // Zero-wait slave, error only in access phase
  assign o_pready  = 1'b1;
  assign o_pslverr = acc & bad;
  assign o_prdata  = rdata_r;

  // State outputs
  assign o_working_register = wreg_r;
  assign o_flags            = flags_r;
  assign o_busy             = busy;
  assign o_skip_dummy       = (st_r == st_dummy);

  // Result and flag logic
  xdm_alu u_alu (
    .i_op      (instr_r.op),
    .i_bit_sel (instr_r.bit_sel),
    .i_wreg    (wreg_r),
    .i_mem     (mem_q_r),
    .i_flags   (flags_r),
    .o_res     (alu_res),
    .o_flags   (alu_flags),
    .o_to_mem  (alu_to_mem),
    .o_to_reg  (alu_to_reg),
    .o_skip    (alu_skip)
  );

  // Sequencer: read, write, optional dummy
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_r <= st_idle;
    end else begin
      case (st_r)
        st_idle: begin
          if (go) begin
            st_r <= st_read;
          end
        end
        st_read: begin
          st_r <= st_write;
        end
        st_write: begin
          // Skip needs a dummy slot while next fetch proceeds
          st_r <= alu_skip ? st_dummy : st_idle;
        end
        st_dummy: begin
          st_r <= st_idle;
        end
        default: begin
          st_r <= st_idle;
        end
      endcase
    end
  end

  // Instruction latch on every CTRL write, with or without GO
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      instr_r <= '0;
    end else if (wr && i_paddr == `XDM_OFF_CTRL) begin
      instr_r.op      <= xdm_op_t'(i_pwdata[`XDM_CTRL_OP_LSB +: 5]);
      instr_r.bit_sel <= i_pwdata[`XDM_CTRL_BIT_LSB +: 3];
      // Whole address taken, no bank select involved
      instr_r.addr    <= i_pwdata[`XDM_CTRL_ADR_LSB +: `XDM_AW];
    end
  end

  // Operand fetch
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      mem_q_r <= 8'h00;
    end else if (st_r == st_read) begin
      mem_q_r <= mem_r[instr_r.addr];
    end
  end

  // Data memory: result commit or bus window write
  always_ff @(posedge i_clk) begin
    if (do_write && alu_to_mem) begin
      mem_r[instr_r.addr] <= alu_res;
    end else if (wr && i_paddr == `XDM_OFF_MDATA) begin
      mem_r[maddr_r] <= i_pwdata[7:0];
    end
  end

  // Memory window pointer
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      maddr_r <= '0;
    end else if (wr && i_paddr == `XDM_OFF_MADDR) begin
      maddr_r <= i_pwdata[`XDM_AW-1:0];
    end
  end

  // Working register
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wreg_r <= `XDM_WREG_RST;
    end else if (do_write && alu_to_reg) begin
      wreg_r <= alu_res;
    end else if (wr && i_paddr == `XDM_OFF_WREG) begin
      wreg_r <= i_pwdata[7:0];
    end
  end

  // Flags: unchanged unless the ALU or a FLAGS write changes them
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      flags_r <= `XDM_FLAGS_RST;
    end else if (do_write) begin
      flags_r <= alu_flags;
    end else if (wr && i_paddr == `XDM_OFF_FLAGS) begin
      flags_r <= xdm_flags_t'(i_pwdata[5:0]);
    end
  end

  // Skip status, set by commit, cleared by next launch
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      skip_r <= 1'b0;
    end else if (do_write) begin
      skip_r <= alu_skip;
    end else if (go) begin
      skip_r <= 1'b0;
    end
  end

  // Length of the instruction in cycles
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cyc_r <= `XDM_CYC_RST;
    end else if (go) begin
      cyc_r <= `XDM_CYC_RST;
    end else if (busy) begin
      cyc_r <= cyc_r + 2'h1;
    end
  end

  // Read data registered in setup phase
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rdata_r <= 32'h0000_0000;
    end else if (setup) begin
      case (i_paddr)
        `XDM_OFF_CTRL: begin
          rdata_r <= {16'h0000, 8'h00, 8'h00} |
                     ({27'h0, instr_r.op} << `XDM_CTRL_OP_LSB) |
                     ({29'h0, instr_r.bit_sel} << `XDM_CTRL_BIT_LSB) |
                     ({23'h0, instr_r.addr} << `XDM_CTRL_ADR_LSB);
        end
        `XDM_OFF_WREG: begin
          rdata_r <= {24'h000000, wreg_r};
        end
        `XDM_OFF_FLAGS: begin
          rdata_r <= {26'h0, flags_r};
        end
        `XDM_OFF_MADDR: begin
          rdata_r <= {23'h0, maddr_r};
        end
        `XDM_OFF_MDATA: begin
          rdata_r <= {24'h000000, mem_r[maddr_r]};
        end
        `XDM_OFF_STAT: begin
          rdata_r <= ({31'h0, busy} << `XDM_STAT_BUSY) |
                     ({31'h0, skip_r} << `XDM_STAT_SKIP) |
                     ({30'h0, cyc_r} << `XDM_STAT_CYC_LSB);
        end
        default: begin
          rdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Checks on launch sequence and committed results
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_move_keeps_flags;
    do_write && instr_r.op == op_far_move_to_memory |=>
      mem_r[instr_r.addr] == $past(wreg_r) && flags_r == $past(flags_r);
  endproperty
  a_move_keeps_flags: assert property (p_move_keeps_flags)
    else $error("move to memory wrong value or flags");

  property p_or_zero_only;
    do_write && instr_r.op == op_far_or_to_register |=>
      wreg_r == ($past(wreg_r) | mem_q_r) && flags_r.z == (wreg_r == 8'h00) &&
      flags_r.c == $past(flags_r.c);
  endproperty
  a_or_zero_only: assert property (p_or_zero_only)
    else $error("OR result or zero flag wrong");

  property p_rotl;
    do_write && instr_r.op == op_far_rotate_left |=>
      mem_r[instr_r.addr] == {mem_q_r[6:0], mem_q_r[7]} && flags_r == $past(flags_r);
  endproperty
  a_rotl: assert property (p_rotl)
    else $error("rotate left wrong");

  property p_rotl_carry;
    do_write && instr_r.op == op_far_rotate_left_thru_carry |=>
      mem_r[instr_r.addr] == {mem_q_r[6:0], $past(flags_r.c)} && flags_r.c == mem_q_r[7];
  endproperty
  a_rotl_carry: assert property (p_rotl_carry)
    else $error("rotate left through carry wrong");

  property p_rotr_carry_reg;
    do_write && instr_r.op == op_far_rotr_thru_carry_to_reg |=>
      wreg_r == {$past(flags_r.c), mem_q_r[7:1]} && flags_r.c == mem_q_r[0] &&
      mem_r[instr_r.addr] == mem_q_r;
  endproperty
  a_rotr_carry_reg: assert property (p_rotr_carry_reg)
    else $error("rotate right through carry to register wrong");

  property p_sub_carry;
    do_write && instr_r.op == op_far_subtract_to_reg |=>
      flags_r.c == ($past(wreg_r) >= mem_q_r);
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("subtract carry wrong");

  property p_dec_skip;
    do_write && instr_r.op == op_far_decrement_skip |=>
      mem_r[instr_r.addr] == mem_q_r - 8'h01 && skip_r == (mem_q_r == 8'h01);
  endproperty
  a_dec_skip: assert property (p_dec_skip)
    else $error("decrement skip wrong");

  property p_skip_len;
    do_write && alu_skip |=> st_r == st_dummy ##1 st_r == st_idle &&
      cyc_r == `XDM_CYC_SKIP;
  endproperty
  a_skip_len: assert property (p_skip_len)
    else $error("skip did not take three cycles");

  property p_launch;
    go |=> st_r == st_read ##1 do_write;
  endproperty
  a_launch: assert property (p_launch)
    else $error("launch sequence wrong");

  property p_swap;
    do_write && instr_r.op == op_far_nibble_exchange |=>
      mem_r[instr_r.addr] == {mem_q_r[3:0], mem_q_r[7:4]};
  endproperty
  a_swap: assert property (p_swap)
    else $error("nibble swap wrong");

  // Main scenarios
  c_skip_taken: cover property (do_write && alu_skip ##2 st_r == st_idle);
  c_sub_to_mem: cover property (do_write && instr_r.op == op_far_subtract_to_mem);
  c_bus_error:  cover property (o_pslverr);

endmodule : xdm_exec

// ### tb/xdm_exec_tb.sv
// Self-checking testbench of the extended data memory executor
`timescale 1ns/10ps
`include "xdm_defines.svh"
module tb;
  import xdm_pkg::*;

  logic        clk     = 1'b0;  // 10 MHz core clock
  logic        rst_b   = 1'b0;  // Synchronous reset, active low
  logic        psel    = 1'b0;  // APB select
  logic        penable = 1'b0;  // APB access phase
  logic        pwrite  = 1'b0;  // APB direction
  logic [7:0]  paddr   = 8'h00; // APB byte address
  logic [31:0] pwdata  = 32'h0; // APB write data
  logic [31:0] prdata;          // APB read data
  logic        pready;          // APB ready
  logic        pslverr;         // APB error
  logic [7:0]  wreg;            // Working register port
  xdm_flags_t  flags;           // Flag port
  logic        busy;            // Instruction running
  logic        skip_dummy;      // Dummy cycle of a taken skip
  int          fail_count  = 0; // Mismatches
  int          check_count = 0; // Comparisons

  xdm_exec u_dut (
    .i_clk              (clk),
    .i_rst_b            (rst_b),
    .i_psel             (psel),
    .i_penable          (penable),
    .i_pwrite           (pwrite),
    .i_paddr            (paddr),
    .i_pwdata           (pwdata),
    .o_prdata           (prdata),
    .o_pready           (pready),
    .o_pslverr          (pslverr),
    .o_working_register (wreg),
    .o_flags            (flags),
    .o_busy             (busy),
    .o_skip_dummy       (skip_dummy)
  );

  // Clock, 100 ns period
  always #50 clk = ~clk;

  // One value comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer: setup, then access until pready at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Hold the request until the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  // Register read
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd

  // Load operands, launch, time the run and check every result
  task automatic run_op(input xdm_op_t op, input logic [2:0] b, input logic [8:0] a,
                        input logic [7:0] m, input logic [7:0] w, input logic [5:0] f,
                        input logic [7:0] ew, input logic [7:0] em, input logic [5:0] ef,
                        input logic sk);
    logic [31:0] q;
    int          cyc;
    int          dum;
    wr(`XDM_OFF_MADDR, {23'h0, a});
    wr(`XDM_OFF_MDATA, {24'h0, m});
    wr(`XDM_OFF_WREG, {24'h0, w});
    wr(`XDM_OFF_FLAGS, {26'h0, f});
    wr(`XDM_OFF_CTRL, {1'b1, 6'h0, a, 5'h0, b, 3'h0, op});
    cyc = 0;
    dum = 0;
    // Count busy edges and dummy edges, bounded
    do begin
      @(posedge clk);
      if (busy === 1'b1) cyc++;
      if (skip_dummy === 1'b1) dum++;
    end while (busy === 1'b1 && cyc < 16);
    chk("busy cycles", {30'h0, sk ? `XDM_CYC_SKIP : `XDM_CYC_PLAIN}, cyc);
    chk("dummy cycles", {31'h0, sk}, dum);
    chk("wreg port", {24'h0, ew}, {24'h0, wreg});
    chk("flags port", {26'h0, ef}, {26'h0, flags});
    rd(`XDM_OFF_WREG, q);
    chk("WREG", {24'h0, ew}, q);
    rd(`XDM_OFF_FLAGS, q);
    chk("FLAGS", {26'h0, ef}, q);
    rd(`XDM_OFF_MDATA, q);
    chk("memory", {24'h0, em}, q);
    rd(`XDM_OFF_STAT, q);
    chk("STAT", {26'h0, sk ? `XDM_CYC_SKIP : `XDM_CYC_PLAIN, 2'h0, sk, 1'b0}, q);
  endtask : run_op

  // Reset values and an unmapped address
  task automatic t_bus();
    logic [31:0] q;
    logic        e;
    rd(`XDM_OFF_WREG, q);
    chk("WREG reset", 32'h0, q);
    rd(`XDM_OFF_FLAGS, q);
    chk("FLAGS reset", 32'h0, q);
    apb(1'b0, 8'h18, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask : t_bus

  // Move and OR, low and high sections
  task automatic t_move_or();
    run_op(op_far_move_to_memory, 3'h0, 9'h1F5, 8'h00, 8'h5A, 6'h3F,
           8'h5A, 8'h5A, 6'h3F, 1'b0);
    run_op(op_far_move_to_memory, 3'h0, 9'h000, 8'hFF, 8'hA5, 6'h00,
           8'hA5, 8'hA5, 6'h00, 1'b0);
    run_op(op_far_or_to_register, 3'h0, 9'h100, 8'h00, 8'h00, 6'h3D,
           8'h00, 8'h00, 6'h3F, 1'b0);
    run_op(op_far_or_to_memory, 3'h0, 9'h0FF, 8'h0A, 8'h50, 6'h3F,
           8'h50, 8'h5A, 6'h3D, 1'b0);
  endtask : t_move_or

  // Rotates, plain and through carry, to memory and register
  task automatic t_rotate();
    run_op(op_far_rotate_left, 3'h0, 9'h010, 8'h81, 8'h11, 6'h3F,
           8'h11, 8'h03, 6'h3F, 1'b0);
    run_op(op_far_rotate_left_to_reg, 3'h0, 9'h011, 8'h81, 8'h00, 6'h00,
           8'h03, 8'h81, 6'h00, 1'b0);
    run_op(op_far_rotate_left_thru_carry, 3'h0, 9'h012, 8'h80, 8'h11, 6'h00,
           8'h11, 8'h00, 6'h01, 1'b0);
    run_op(op_far_rotl_thru_carry_to_reg, 3'h0, 9'h013, 8'h01, 8'h00, 6'h3F,
           8'h03, 8'h01, 6'h3E, 1'b0);
    run_op(op_far_rotate_right, 3'h0, 9'h014, 8'h01, 8'h11, 6'h00,
           8'h11, 8'h80, 6'h00, 1'b0);
    run_op(op_far_rotate_right_to_reg, 3'h0, 9'h015, 8'h02, 8'h00, 6'h3F,
           8'h01, 8'h02, 6'h3F, 1'b0);
    run_op(op_far_rotate_right_thru_carry, 3'h0, 9'h016, 8'h01, 8'h11, 6'h00,
           8'h11, 8'h00, 6'h01, 1'b0);
    run_op(op_far_rotr_thru_carry_to_reg, 3'h0, 9'h017, 8'h80, 8'h00, 6'h01,
           8'hC0, 8'h80, 6'h00, 1'b0);
  endtask : t_rotate

  // Subtracts: negative, signed overflow, zero with chain, borrow in
  task automatic t_sub();
    run_op(op_far_subtract_to_reg, 3'h0, 9'h020, 8'h06, 8'h05, 6'h00,
           8'hFF, 8'h06, 6'h10, 1'b0);
    run_op(op_far_subtract_to_mem, 3'h0, 9'h021, 8'h01, 8'h80, 6'h00,
           8'h80, 8'h7F, 6'h19, 1'b0);
    run_op(op_far_subtract_borrow_to_reg, 3'h0, 9'h022, 8'h05, 8'h05, 6'h21,
           8'h00, 8'h05, 6'h27, 1'b0);
    run_op(op_far_subtract_borrow_to_mem, 3'h0, 9'h023, 8'h01, 8'h10, 6'h20,
           8'h10, 8'h0E, 6'h01, 1'b0);
  endtask : t_sub

  // Decrement and increment skips, taken and not taken
  task automatic t_step_skip();
    run_op(op_far_decrement_skip, 3'h0, 9'h030, 8'h01, 8'h11, 6'h2A,
           8'h11, 8'h00, 6'h2A, 1'b1);
    run_op(op_far_decrement_skip_to_reg, 3'h0, 9'h031, 8'h05, 8'h11, 6'h15,
           8'h04, 8'h05, 6'h15, 1'b0);
    run_op(op_far_increment_skip, 3'h0, 9'h032, 8'h7F, 8'h11, 6'h2A,
           8'h11, 8'h80, 6'h2A, 1'b0);
    run_op(op_far_increment_skip_to_reg, 3'h0, 9'h033, 8'hFF, 8'h11, 6'h15,
           8'h00, 8'hFF, 6'h15, 1'b1);
  endtask : t_step_skip

  // Set, bit set, tests and nibble swap
  task automatic t_set_test();
    run_op(op_far_set_ones, 3'h0, 9'h040, 8'h00, 8'h11, 6'h2A,
           8'h11, 8'hFF, 6'h2A, 1'b0);
    run_op(op_far_set_ones_bit, 3'h7, 9'h041, 8'h01, 8'h11, 6'h15,
           8'h11, 8'h81, 6'h15, 1'b0);
    run_op(op_far_nonzero_test_skip_bit, 3'h7, 9'h042, 8'h80, 8'h11, 6'h2A,
           8'h11, 8'h80, 6'h2A, 1'b1);
    run_op(op_far_nonzero_test_skip_bit, 3'h0, 9'h043, 8'hFE, 8'h11, 6'h15,
           8'h11, 8'hFE, 6'h15, 1'b0);
    run_op(op_far_nonzero_test_skip, 3'h0, 9'h044, 8'h00, 8'h11, 6'h2A,
           8'h11, 8'h00, 6'h2A, 1'b0);
    run_op(op_far_nonzero_test_skip, 3'h0, 9'h045, 8'h40, 8'h11, 6'h15,
           8'h11, 8'h40, 6'h15, 1'b1);
    run_op(op_far_nibble_exchange, 3'h0, 9'h1A0, 8'hA5, 8'h11, 6'h2A,
           8'h11, 8'h5A, 6'h2A, 1'b0);
  endtask : t_set_test

  // Write refused while a taken skip is still in its dummy slot
  task automatic t_busy_refuse();
    logic [31:0] q;
    logic        e;
    wr(`XDM_OFF_MADDR, 32'h0000_0050);
    wr(`XDM_OFF_MDATA, 32'h0000_0001);
    wr(`XDM_OFF_WREG, 32'h0000_0011);
    wr(`XDM_OFF_CTRL, {1'b1, 6'h0, 9'h050, 5'h0, 3'h0, 3'h0, op_far_decrement_skip});
    // Access cycle of this write falls in the dummy slot
    apb(1'b1, `XDM_OFF_WREG, 32'h0000_0077, q, e);
    chk("busy write error", 32'h1, {31'h0, e});
    rd(`XDM_OFF_WREG, q);
    chk("busy write ignored", 32'h11, q);
    rd(`XDM_OFF_MDATA, q);
    chk("memory after skip", 32'h0, q);
  endtask : t_busy_refuse

  // Counts, verdict and end of run
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // Main sequence after 16 reset cycles
  initial begin : main
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_bus();
    t_move_or();
    t_rotate();
    t_sub();
    t_step_skip();
    t_set_test();
    t_busy_refuse();
    close_out();
  end

  // Watchdog, far beyond the some 860 cycles needed
  initial begin : watchdog
    #2000000;
    fail_count++;
    close_out();
  end

endmodule : tb
